//--- inc/sba_bus_if.sv
// Shared address phase wires between the device end and the agent end
`timescale 1ns/1ps
`default_nettype none
interface sba_bus_if;
  import sba_pkg::*;
  sba_addr_t devAddrN;
  sba_addr_t devAddrOe;
  logic devStrobeN;
  logic devStrobeOe;
  logic [1:0] devParN;
  logic devParOe;
  sba_req_t devReqN;
  logic devReqParN;
  logic devErrOe;
  sba_addr_t agtAddrN;
  sba_addr_t agtAddrOe;
  logic agtStrobeN;
  logic agtStrobeOe;
  logic [1:0] agtParN;
  logic agtParOe;
  sba_req_t agtReqN;
  logic agtReqParN;
  logic agtErrOe;
  // Resolved wire levels (pulled up, driven low; request code and its parity taken whole from the driving end)
  sba_addr_t addrN;
  logic addr_strobe_n;
  logic [1:0] addr_parity_n;
  sba_req_t reqN;
  logic req_parity_n;
  logic addr_parity_err_n;
  assign addrN = ~((devAddrOe & ~devAddrN) | (agtAddrOe & ~agtAddrN));
  assign addr_strobe_n = ~((devStrobeOe & ~devStrobeN) | (agtStrobeOe & ~agtStrobeN));
  assign addr_parity_n = ~(({2{devParOe}} & ~devParN) | ({2{agtParOe}} & ~agtParN));
  assign reqN = devStrobeOe ? devReqN : (agtStrobeOe ? agtReqN : '1);
  assign req_parity_n = devStrobeOe ? devReqParN : (agtStrobeOe ? agtReqParN : 1'b1);
  assign addr_parity_err_n = ~(devErrOe | agtErrOe);
  modport device (
    output devAddrN, devAddrOe, devStrobeN, devStrobeOe, devParN, devParOe,
    output devReqN, devReqParN, devErrOe,
    input addrN, addr_strobe_n, addr_parity_n, reqN, req_parity_n, addr_parity_err_n
  );
  modport agent (
    output agtAddrN, agtAddrOe, agtStrobeN, agtStrobeOe, agtParN, agtParOe,
    output agtReqN, agtReqParN, agtErrOe,
    input addrN, addr_strobe_n, addr_parity_n, reqN, req_parity_n, addr_parity_err_n
  );
endinterface
`default_nettype wire

//--- inc/sba_pkg.sv
// Shared constants and types for the system bus address phase ends
package sba_pkg;
  localparam int ADDR_HI = 35;
  localparam int ADDR_LO = 3;
  localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
  localparam int PAR_SPLIT = 24;
  localparam int REQ_W = 5;
  localparam int MASK_BIT = 20;
  localparam int CFG_ADDR_PARITY_ERR_N_OBS_BIT = 4;
  localparam int CFG_ADDR_PARITY_ERR_N_DRV_BIT = 5;
  typedef logic [ADDR_HI:ADDR_LO] sba_addr_t;
  typedef logic [REQ_W-1:0] sba_req_t;

  // Active-low even parity: high when an even number of covered lines are low
  function automatic logic [1:0] sba_par_n(input sba_addr_t linesN);
    logic hi;
    logic lo;
    hi = ~(^(~linesN[ADDR_HI:PAR_SPLIT]));
    lo = ~(^(~linesN[PAR_SPLIT-1:ADDR_LO]));
    return {hi, lo};
  endfunction
endpackage

//--- logic/sba_agent_end.sv
// Other agent end: issues requests, checks parity, drives config straps
`timescale 1ns/1ps
`default_nettype none
module sba_agent_end
  import sba_pkg::*;
(
  input wire logic sys_clk, // Bus clock
  input wire logic srst, // Synchronous reset, high
  sba_bus_if.agent bus, // Shared bus wires
  input wire sba_addr_t strapWord, // Config values held during reset
  input wire logic reqValid, // Issue a request, one cycle
  input wire sba_addr_t reqAddr, // Address, true polarity
  input wire sba_addr_t reqType, // Type info, true polarity
  input wire sba_req_t reqCode, // Request code, true polarity
  output logic reqBusy, // Request ignored while high
  output logic snoopStart, // Transaction seen, one cycle
  output sba_addr_t snoopAddr, // Its address, true polarity
  output logic errSeen // Error line seen low, one cycle
);
  import sba_pkg::*;

  typedef enum logic [1:0] {AG_IDLE, AG_ADDR, AG_TYPE} ag_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Issue sequencer, same timing as the device end
  ag_state_e state_q;
  logic strap_q;
  sba_addr_t addrOut_q;
  sba_addr_t typeHold_q;
  logic [1:0] parOut_q;
  sba_req_t reqOut_q;
  logic reqParOut_q;
  logic start;
  assign start = (state_q == AG_IDLE) & reqValid & ~strap_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= AG_IDLE;
    end else begin
      case (state_q)
        AG_IDLE: state_q <= start ? AG_ADDR : AG_IDLE;
        AG_ADDR: state_q <= AG_TYPE;
        default: state_q <= AG_IDLE;
      endcase
    end
  end

  // Straps stay on the lines through reset and the release edge
  always_ff @(posedge sys_clk) begin
    strap_q <= srst;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addrOut_q <= '1;
      parOut_q <= 2'h3;
      reqOut_q <= '1;
      reqParOut_q <= 1'b1;
      typeHold_q <= '0;
    end else if (start) begin
      addrOut_q <= ~reqAddr;
      parOut_q <= sba_par_n(~reqAddr);
      reqOut_q <= ~reqCode;
      reqParOut_q <= ^reqCode;
      typeHold_q <= reqType;
    end else if (state_q == AG_ADDR) begin
      addrOut_q <= ~typeHold_q;
    end
  end

  logic driving;
  assign driving = (state_q != AG_IDLE);
  assign reqBusy = driving | strap_q | srst;
  assign bus.agtAddrN = (srst | strap_q) ? ~strapWord : addrOut_q;
  assign bus.agtAddrOe = (srst | strap_q | driving) ? '1 : '0;
  assign bus.agtStrobeN = ~(state_q == AG_ADDR);
  assign bus.agtStrobeOe = driving;
  assign bus.agtParN = parOut_q;
  assign bus.agtParOe = (state_q == AG_ADDR);
  assign bus.agtReqN = reqOut_q;
  assign bus.agtReqParN = reqParOut_q;

  ////////////////////////////////////////////////////////////////////////////
  // Observer: check parity on every strobe and report on the error line
  logic strobeSeen;
  logic bad_q;
  assign strobeSeen = ~bus.addr_strobe_n & ~srst & ~strap_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      snoopStart <= 1'b0;
      snoopAddr <= '0;
      bad_q <= 1'b0;
      errSeen <= 1'b0;
    end else begin
      snoopStart <= strobeSeen;
      snoopAddr <= strobeSeen ? ~bus.addrN : snoopAddr;
      bad_q <= strobeSeen & (bus.addr_parity_n != sba_par_n(bus.addrN));
      errSeen <= ~bus.addr_parity_err_n;
    end
  end

  assign bus.agtErrOe = bad_q;
endmodule
`default_nettype wire

//--- logic/sba_device_end.sv
// Device end of the address phase: issue, check, config sampling, bit 20 mask
`timescale 1ns/1ps
`default_nettype none
module sba_device_end
  import sba_pkg::*;
(
  input wire logic sys_clk, // Bus clock
  input wire logic srst, // Synchronous reset, high
  sba_bus_if.device bus, // Shared bus wires
  input wire logic reqValid, // Issue a request, one cycle
  input wire sba_addr_t reqAddr, // Physical byte address, true polarity
  input wire sba_addr_t reqType, // Type info for the cycle after the strobe
  input wire sba_req_t reqCode, // Request type code, true polarity
  input wire logic addr_bit20_mask_n, // Bit 20 mask pin, async, low active
  input wire logic lookupValid, // Internal cache lookup request
  input wire sba_addr_t lookupAddr, // Lookup address before masking
  output logic reqBusy, // Request ignored while high
  output sba_addr_t lookupAddrMasked, // Lookup address after masking
  output sba_addr_t cfgWord, // Power-on configuration, true polarity
  output logic cfgValid, // Configuration captured
  output logic snoopStart, // New transaction seen on the bus
  output sba_addr_t snoopAddr, // Its address, true polarity
  output logic parityErr, // Mismatch detected, one cycle
  output logic txnAbort // Current transaction aborted, one cycle
);
  import sba_pkg::*;

  typedef enum logic [1:0] {SBA_IDLE, SBA_ADDR, SBA_TYPE} sba_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Mask synchroniser: the pin is asynchronous so it passes two flops
  logic maskMeta_q;
  logic maskSync_q;
  always_ff @(posedge sys_clk) begin
    maskMeta_q <= ~addr_bit20_mask_n;
    maskSync_q <= maskMeta_q;
  end

  // Masking function applied to cache lookups and bus requests
  function automatic sba_addr_t mask20(input sba_addr_t a, input logic m);
    sba_addr_t r;
    r = a;
    if (m) begin
      r[MASK_BIT] = 1'b0;
    end
    return r;
  endfunction

  sba_addr_t issueAddr;
  sba_addr_t lookupNext;
  assign issueAddr = mask20(reqAddr, maskSync_q);
  assign lookupNext = mask20(lookupAddr, maskSync_q);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lookupAddrMasked <= '0;
    end else if (lookupValid) begin
      lookupAddrMasked <= lookupNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request issue: strobe cycle carries address, next cycle carries type
  sba_state_e state_q;
  sba_state_e state_d;
  sba_addr_t typeHold_q;
  sba_addr_t addrOut_q;
  logic [1:0] parOut_q;
  sba_req_t reqOut_q;
  logic reqParOut_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      SBA_IDLE: begin
        if (reqValid) begin
          state_d = SBA_ADDR;
        end
      end
      SBA_ADDR: state_d = SBA_TYPE;
      default: state_d = SBA_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= SBA_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Line drivers are registered; values are inverted to active-low before the register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addrOut_q <= '1;
      parOut_q <= 2'h3;
      reqOut_q <= '1;
      reqParOut_q <= 1'b1;
      typeHold_q <= '0;
    end else if (state_q == SBA_IDLE && reqValid) begin
      addrOut_q <= ~issueAddr;
      parOut_q <= sba_par_n(~issueAddr);
      reqOut_q <= ~reqCode;
      reqParOut_q <= ^reqCode;
      typeHold_q <= reqType;
    end else if (state_q == SBA_ADDR) begin
      addrOut_q <= ~typeHold_q;
    end
  end

  assign reqBusy = (state_q != SBA_IDLE);
  assign bus.devAddrN = addrOut_q;
  assign bus.devAddrOe = (state_q != SBA_IDLE) ? '1 : '0;
  assign bus.devStrobeN = ~(state_q == SBA_ADDR);
  assign bus.devStrobeOe = (state_q != SBA_IDLE);
  assign bus.devParN = parOut_q;
  assign bus.devParOe = (state_q == SBA_ADDR);
  assign bus.devReqN = reqOut_q;
  assign bus.devReqParN = reqParOut_q;

  ////////////////////////////////////////////////////////////////////////////
  // Power-on configuration: capture lines on the first edge after release
  logic rstSeen_q;
  always_ff @(posedge sys_clk) begin
    rstSeen_q <= srst;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfgWord <= '0;
      cfgValid <= 1'b0;
    end else if (rstSeen_q) begin
      cfgWord <= ~bus.addrN;
      cfgValid <= 1'b1;
    end
  end

  logic obsEn;
  logic drvEn;
  assign obsEn = cfgValid & cfgWord[CFG_ADDR_PARITY_ERR_N_OBS_BIT];
  assign drvEn = cfgValid & cfgWord[CFG_ADDR_PARITY_ERR_N_DRV_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Observer: every strobe starts snoop and parity check
  logic strobeSeen;
  logic parBad;
  assign strobeSeen = ~bus.addr_strobe_n & cfgValid;
  assign parBad = strobeSeen & (bus.addr_parity_n != sba_par_n(bus.addrN));

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      snoopStart <= 1'b0;
      snoopAddr <= '0;
      parityErr <= 1'b0;
    end else begin
      snoopStart <= strobeSeen;
      snoopAddr <= strobeSeen ? ~bus.addrN : snoopAddr;
      parityErr <= parBad;
    end
  end

  // Error line pulled one cycle after the strobe, if the driver is enabled
  assign bus.devErrOe = parityErr & drvEn;

  // Abort only when observation was enabled at configuration; else ignored
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      txnAbort <= 1'b0;
    end else begin
      txnAbort <= obsEn & ~bus.addr_parity_err_n;
    end
  end
endmodule
`default_nettype wire

//--- sim/sba_check_sva.sv
// Concurrent checks on the wires between the device end and the agent end
`timescale 1ns/1ps
`default_nettype none
module sba_check_sva
  import sba_pkg::*;
(
  input wire logic sys_clk, // Bus clock
  input wire logic srst, // Sync reset
  input wire sba_addr_t addrN, // Address lines
  input wire logic addr_strobe_n, // Strobe line
  input wire logic [1:0] addr_parity_n, // Parity lines
  input wire sba_addr_t devAddrN, // Device address
  input wire sba_addr_t devAddrOe, // Device address enable
  input wire logic devStrobeN, // Device strobe
  input wire logic devStrobeOe, // Device strobe enable
  input wire logic [1:0] devParN, // Device parity
  input wire logic devParOe, // Device parity enable
  input wire logic devErrOe // Device error drive
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  // Parity rebuilt from levels; kept apart from the shared package function
  logic [1:0] busPar;
  logic [1:0] devPar;
  assign busPar = {~^(~addrN[35:24]), ~^(~addrN[23:3])};
  assign devPar = {~^(~devAddrN[35:24]), ~^(~devAddrN[23:3])};
  ////////////////////////////////////////////////////////////////////////////////
  // Address phase checks
  a_bus_parity_ok: assert property (!addr_strobe_n |-> addr_parity_n == busPar)
    else $error("bus parity wrong in strobe cycle");
  a_dev_parity_ok: assert property (devParOe && !devStrobeN |-> devParN == devPar)
    else $error("device parity wrong");
  a_par_with_strobe: assert property (devStrobeOe && !devStrobeN |-> devParOe)
    else $error("parity not driven with strobe");
  a_strobe_addr_all: assert property (devStrobeOe && !devStrobeN |-> devAddrOe == '1)
    else $error("address lines not all driven");
  a_strobe_single: assert property ($fell(addr_strobe_n) |=> addr_strobe_n [*2])
    else $error("strobe longer than one cycle");
  a_type_then_free: assert property (devStrobeOe && !devStrobeN |=>
    devStrobeOe && devStrobeN ##1 !devStrobeOe && devAddrOe == '0)
    else $error("type cycle or release missing");
  a_reset_quiet: assert property ($fell(srst) |-> !devStrobeOe && devAddrOe == '0 && !devErrOe)
    else $error("device drives during config sampling");
  a_err_has_cause: assert property ($rose(devErrOe) |->
    $past(addr_strobe_n, 1) == 1'b0 || $past(addr_strobe_n, 2) == 1'b0)
    else $error("error line without a strobe");
endmodule
`default_nettype wire

//--- sim/system_bus_address_phase_test.sv
// Bench joining device end and agent end, plus a lone device facing a bad agent
`timescale 1ns/1ps
`default_nettype none
module system_bus_address_phase_test;
  import sba_pkg::*;
  localparam sba_addr_t STRAP = 33'h0_A5A5_0036; // Observe and drive error enabled
  localparam sba_addr_t TBL [4] = '{33'h0, 33'h1_FFFF_FFFF, 33'h0_0000_0001, 33'h1_0000_0000};
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic dRv = 1'b0;
  logic aRv = 1'b0;
  logic lkV = 1'b0;
  logic maskN = 1'b1;
  sba_addr_t dAddr = '0;
  sba_addr_t aAddr = '0;
  sba_addr_t lkA = '0;
  sba_req_t dCode = 5'h15;
  sba_req_t aCode = 5'h0A;
  sba_addr_t lkOut, cfg1, sAddrD, sAddrA;
  logic sD, sA, pe1, pe2, ab2, cv2;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  sba_bus_if bus1();
  sba_bus_if bus2();
  ////////////////////////////////////////////////////////////////////////////////
  // Design ends and checker
  sba_device_end sba_device_end_inst (.sys_clk(sys_clk), .srst(srst), .bus(bus1.device),
    .reqValid(dRv), .reqAddr(dAddr), .reqType(~dAddr), .reqCode(dCode),
    .addr_bit20_mask_n(maskN), .lookupValid(lkV), .lookupAddr(lkA), .reqBusy(),
    .lookupAddrMasked(lkOut), .cfgWord(cfg1), .cfgValid(), .snoopStart(sD),
    .snoopAddr(sAddrD), .parityErr(pe1), .txnAbort());
  sba_agent_end sba_agent_end_inst (.sys_clk(sys_clk), .srst(srst), .bus(bus1.agent),
    .strapWord(STRAP), .reqValid(aRv), .reqAddr(aAddr), .reqType(~aAddr), .reqCode(aCode),
    .reqBusy(), .snoopStart(sA), .snoopAddr(sAddrA), .errSeen());
  // Second device sees only the bench, so its request side stays idle
  sba_device_end sba_device_end_inst2 (.sys_clk(sys_clk), .srst(srst), .bus(bus2.device),
    .reqValid(1'b0), .reqAddr(dAddr), .reqType(dAddr), .reqCode(dCode),
    .addr_bit20_mask_n(maskN), .lookupValid(1'b0), .lookupAddr(lkA), .reqBusy(),
    .lookupAddrMasked(), .cfgWord(), .cfgValid(cv2), .snoopStart(), .snoopAddr(),
    .parityErr(pe2), .txnAbort(ab2));
  sba_check_sva sba_check_sva_inst (.sys_clk(sys_clk), .srst(srst), .addrN(bus1.addrN),
    .addr_strobe_n(bus1.addr_strobe_n), .addr_parity_n(bus1.addr_parity_n),
    .devAddrN(bus1.devAddrN), .devAddrOe(bus1.devAddrOe), .devStrobeN(bus1.devStrobeN),
    .devStrobeOe(bus1.devStrobeOe), .devParN(bus1.devParN), .devParOe(bus1.devParOe),
    .devErrOe(bus1.devErrOe));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; a normal run needs under a hundred cycles
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  function automatic logic [1:0] par(input sba_addr_t a);
    return {~^a[35:24], ~^a[23:3]};
  endfunction
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Bench plays the far agent of the second bus, parity given as levels
  task drive2(input logic oe, input logic s, input sba_addr_t a, input logic [1:0] p);
    bus2.agtAddrOe = {ADDR_W{oe}};
    bus2.agtAddrN = a;
    bus2.agtStrobeOe = oe;
    bus2.agtStrobeN = s;
    bus2.agtParOe = oe;
    bus2.agtParN = p;
    bus2.agtReqN = '1;
    bus2.agtReqParN = 1'b1;
    bus2.agtErrOe = 1'b0;
  endtask
  task issue(input logic agt, input sba_addr_t a, input sba_addr_t ea);
    @(negedge sys_clk);
    if (agt) begin
      aAddr = a;
      aRv = 1'b1;
    end else begin
      dAddr = a;
      dRv = 1'b1;
    end
    @(negedge sys_clk);
    dRv = 1'b0;
    aRv = 1'b0;
    chk(bus1.addr_strobe_n, 1'b0);
    chk(bus1.addrN, sba_addr_t'(~ea));
    chk(bus1.addr_parity_n, par(ea));
    chk(bus1.reqN, sba_req_t'(agt ? ~aCode : ~dCode));
    @(negedge sys_clk);
    chk(bus1.addrN, a);
    chk(agt ? sD : sA, 1'b1);
    chk(agt ? sAddrD : sAddrA, ea);
    chk(pe1, 1'b0);
    @(negedge sys_clk);
  endtask
  task look(input sba_addr_t ea);
    lkV = 1'b1;
    @(negedge sys_clk);
    lkV = 1'b0;
    @(negedge sys_clk);
    chk(lkOut, ea);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_traffic;
    for (int i = 0; i < 8; i++) begin
      issue(i[0], TBL[i / 2], TBL[i / 2]);
    end
    $display("traffic done");
  endtask
  task t_mask;
    maskN = 1'b0;
    repeat (4) @(negedge sys_clk);
    issue(1'b0, 33'h0_0002_0001, 33'h0_0000_0001);
    lkA = 33'h0_0002_0001;
    look(33'h0_0000_0001);
    maskN = 1'b1;
    repeat (4) @(negedge sys_clk);
    look(lkA);
    $display("mask done");
  endtask
  // Good or broken parity from the bench agent; error and abort must follow only a break
  task t_bus2(input logic bad);
    logic e, t, pe;
    @(negedge sys_clk);
    drive2(1'b1, 1'b0, ~33'h1_2345_6789, par(33'h1_2345_6789) ^ {2{bad}});
    @(negedge sys_clk);
    pe = pe2;
    e = !bus2.addr_parity_err_n;
    t = 1'b0;
    drive2(1'b0, 1'b1, '1, 2'h3);
    repeat (3) begin
      @(negedge sys_clk);
      e |= !bus2.addr_parity_err_n;
      t |= ab2;
    end
    chk(pe, bad);
    chk(e, bad);
    chk(t, bad);
    $display("parity error case %0d done", bad);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: straps stand through reset and the first edge after it
  initial begin
    drive2(1'b1, 1'b1, ~STRAP, 2'h3);
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    drive2(1'b0, 1'b1, '1, 2'h3);
    chk(cfg1, STRAP);
    chk(cv2, 1'b1);
    @(negedge sys_clk);
    chk(bus2.addrN, sba_addr_t'('1));
    $display("config done");
    t_traffic;
    t_mask;
    t_bus2(1'b0);
    t_bus2(1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
